// file: core/sfr_pkg.sv
// Function
// [R1] Addressing starts 24-bit after power-up
// [R2] Enter command sets wide flag, 32-bit addresses
// [R3] Wide mode ends only by exit/reset
// [R4] Exit command clears flag, back to 24-bit
// [R5] Wide mode only lengthens the address field
// [R6] Parameter, signature, ID reads keep 24-bit
// [R7] Host sends mode opcodes alone
// [R8] Sample on rising edge, drive on falling
// [R9] Any start byte, address increments per byte
// [R10] Address wraps to zero past the top
// [R11] Normal read: no dummies, host may abort
// [R12] Fast read: 8 dummy clocks by default
// [R13] Busy device rejects fast and dual reads
// [R14] Dual output: single-line header, two-bit data
// [R15] Dual address/data: two-bit address, 4 dummies
// [R16] Dummy count from two configuration bits
// [R17] Extended address bits supply upper address
// [R18] Host holds write-protect high during write
// [R19] MSB first, higher pair bit on line one
package sfr_pkg;

  // Command opcodes
  localparam logic [7:0] OP_READ            = 8'h03;
  localparam logic [7:0] OP_FAST_READ       = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT_READ   = 8'h3b;
  localparam logic [7:0] OP_DUAL_ADDR_READ  = 8'hbb;
  localparam logic [7:0] OP_ENTER_WIDE      = 8'hb7;
  localparam logic [7:0] OP_EXIT_WIDE       = 8'he9;
  localparam logic [7:0] OP_PARAM_TABLE     = 8'h5a;
  localparam logic [7:0] OP_SIGNATURE       = 8'hab;
  localparam logic [7:0] OP_MAKER_ID        = 8'h90;

  // Field sizes in bits
  localparam logic [5:0] OPCODE_BITS        = 6'h08;
  localparam logic [5:0] SHORT_ADDR_BITS    = 6'h18;
  localparam logic [5:0] WIDE_ADDR_BITS     = 6'h20;
  localparam logic [5:0] BYTE_BITS          = 6'h08;

  // Array size: 512 Mbit of bytes
  localparam int unsigned MEM_ADDR_BITS     = 26;

  // Values after reset
  localparam logic        WIDE_FLAG_RESET   = 1'b0;
  localparam logic [1:0]  DUMMY_CFG_RESET   = 2'h0;

  // Dummy clocks per config code, nibble n is code n
  localparam logic [15:0] DUMMY_TABLE_OUT   = 16'ha868;
  localparam logic [15:0] DUMMY_TABLE_DUAL  = 16'ha864;

  // Link-side sequencer states
  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } sfr_state_e;

endpackage

// file: core/sfr_sync.sv
`timescale 1ns/1ns
`default_nettype none

module sfr_sync #(
  parameter int unsigned W = 1
) (
  // Destination clock
  input  wire logic         i_clk,
  // Level from the other domain
  input  wire logic [W-1:0] i_d,
  // Synchronised level
  output logic      [W-1:0] o_q
);

  // A zero-width crossing has nothing to carry
  if (W < 1) begin : g_bad_w
    $error("W must be at least 1");
  end

  logic [W-1:0] meta_q;

  // Two-stage capture; first stage feeds only the second
  always_ff @(posedge i_clk) begin
    meta_q <= i_d;
    o_q    <= meta_q;
  end

endmodule

`default_nettype wire

// file: core/sfr_core.sv
`timescale 1ns/1ns
`default_nettype none

module sfr_core #(
  parameter int unsigned MEM_AW = sfr_pkg::MEM_ADDR_BITS
) (
  // System clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  // Device status and configuration
  input  wire logic              i_write_cycle_busy,
  input  wire logic              i_dummy_count_bit_low,
  input  wire logic              i_dummy_count_bit_high,
  input  wire logic [7:0]        i_extended_address_bit,
  output logic                   o_wide_address_flag,
  // Array load port
  input  wire logic              i_load_en,
  input  wire logic [MEM_AW-1:0] i_load_addr,
  input  wire logic [7:0]        i_load_data,
  // Serial link
  input  wire logic              i_sclk,
  input  wire logic              i_cs_n,
  input  wire logic              i_io_line_zero,
  input  wire logic              i_io_line_one,
  output logic                   o_io_line_zero,
  output logic                   o_io_line_zero_oe,
  output logic                   o_io_line_one,
  output logic                   o_io_line_one_oe
);

  // Refuse array sizes the address path cannot carry
  if (MEM_AW < 8) begin : g_small_aw
    $error("MEM_AW must be at least 8");
  end

  // Array depth is reckoned in a 32-bit int; larger widths overflow it
  if (MEM_AW > 30) begin : g_bad_aw
    $error("MEM_AW must be at most 30");
  end

  // Command decoding helpers

  // Opcodes that stream array data
  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == sfr_pkg::OP_READ) || (op == sfr_pkg::OP_FAST_READ) ||
              (op == sfr_pkg::OP_DUAL_OUT_READ) || (op == sfr_pkg::OP_DUAL_ADDR_READ);
  endfunction

  // Fast and dual reads refused while a write cycle runs
  function automatic logic is_busy_refused(input logic [7:0] op);
    is_busy_refused = (op == sfr_pkg::OP_FAST_READ) ||
                      (op == sfr_pkg::OP_DUAL_OUT_READ) ||
                      (op == sfr_pkg::OP_DUAL_ADDR_READ);
  endfunction

  // Commands that keep the short address whatever the mode
  function automatic logic is_short_only(input logic [7:0] op);
    is_short_only = (op == sfr_pkg::OP_PARAM_TABLE) || (op == sfr_pkg::OP_SIGNATURE) ||
                    (op == sfr_pkg::OP_MAKER_ID);
  endfunction

  // Address length for a command in the current mode
  function automatic logic [5:0] addr_bits(input logic [7:0] op, input logic wide);
    if (wide && !is_short_only(op)) begin
      addr_bits = sfr_pkg::WIDE_ADDR_BITS;                       // [R5]
    end else begin
      addr_bits = sfr_pkg::SHORT_ADDR_BITS;                      // [R1] [R6]
    end
  endfunction

  // Dummy clocks for a read from the two config bits
  function automatic logic [3:0] dummy_clocks(input logic [7:0] op, input logic [1:0] dc);
    if (op == sfr_pkg::OP_DUAL_ADDR_READ) begin
      dummy_clocks = sfr_pkg::DUMMY_TABLE_DUAL[{dc, 2'b00} +: 4]; // [R15] [R16]
    end else if (op == sfr_pkg::OP_READ) begin
      dummy_clocks = 4'h0;                                        // [R11]
    end else begin
      dummy_clocks = sfr_pkg::DUMMY_TABLE_OUT[{dc, 2'b00} +: 4];  // [R12] [R14] [R16]
    end
  endfunction

  // Byte array: loaded on the system clock, read on the link

  logic [7:0] mem [0:(1 << MEM_AW) - 1];

  // Load port write
  always_ff @(posedge i_clk) begin
    if (i_load_en) begin
      mem[i_load_addr] <= i_load_data;
    end
  end

  // Crossings

  // Flag, mode toggle handshake and synchronised copies
  logic             wide_q;
  logic [1:0]       mode_tog_q;
  logic [1:0]       mode_tog_s;
  logic [1:0]       mode_ack_q;
  logic             wide_s;
  logic             busy_s;
  logic [1:0]       dc_s;
  logic [7:0]       ext_s;

  // Configuration and status into the link domain
  sfr_sync #(
    .W (12)
  ) u_to_link (
    .i_clk (i_sclk),
    .i_d   ({wide_q, i_write_cycle_busy, i_dummy_count_bit_high,
             i_dummy_count_bit_low, i_extended_address_bit}),
    .o_q   ({wide_s, busy_s, dc_s, ext_s})
  );

  // Mode-change toggles into the system domain
  sfr_sync #(
    .W (2)
  ) u_to_sys (
    .i_clk (i_clk),
    .i_d   (mode_tog_q),
    .o_q   (mode_tog_s)
  );

  // Wide addressing flag (system domain)

  // A toggle not yet acknowledged marks a fresh mode command
  wire enter_evt = mode_tog_s[0] ^ mode_ack_q[0];
  wire exit_evt  = mode_tog_s[1] ^ mode_ack_q[1];

  // Flag changes only on reset or the two mode commands
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wide_q     <= sfr_pkg::WIDE_FLAG_RESET;                    // [R1] [R3]
      mode_ack_q <= 2'b00;
    end else begin
      mode_ack_q <= mode_tog_s;
      if (enter_evt) begin
        wide_q <= 1'b1;                                          // [R2]
      end else if (exit_evt) begin
        wide_q <= 1'b0;                                          // [R4]
      end
    end
  end

  // Flag output
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_wide_address_flag <= sfr_pkg::WIDE_FLAG_RESET;
    end else begin
      o_wide_address_flag <= wide_q;
    end
  end

  // Link sequencer (rising serial clock, aborted by chip select)

  // Frame registers and their next values
  sfr_pkg::sfr_state_e state_q, state_d;
  logic [5:0]          cnt_q, cnt_d;
  logic [7:0]          op_q, op_d;
  logic [31:0]         addr_sr_q, addr_sr_d;
  logic [MEM_AW-1:0]   addr_q, addr_d;
  logic [7:0]          shift_q, shift_d;
  logic                read_q, read_d;
  logic                dual_in_q, dual_in_d;
  logic                dual_out_q, dual_out_d;
  logic [5:0]          addr_edges_q, addr_edges_d;
  logic [3:0]          dummy_q, dummy_d;

  // Incoming bit decode
  wire [7:0]  op_next    = {op_q[6:0], i_io_line_zero};
  wire        op_done    = (state_q == sfr_pkg::ST_OPCODE) &&
                           (cnt_q == sfr_pkg::OPCODE_BITS - 6'h01);
  wire [31:0] sr_next    = dual_in_q ? {addr_sr_q[29:0], i_io_line_one, i_io_line_zero}
                                     : {addr_sr_q[30:0], i_io_line_zero};
  wire [31:0] full_addr  = wide_s ? sr_next : {ext_s, sr_next[23:0]};   // [R17]
  wire        addr_last  = (state_q == sfr_pkg::ST_ADDR) && (cnt_q == addr_edges_q - 6'h01);
  wire        dummy_last = (state_q == sfr_pkg::ST_DUMMY) &&
                           (cnt_q == {2'b00, dummy_q} - 6'h01);
  wire [5:0]  byte_edges = dual_out_q ? 6'h04 : sfr_pkg::BYTE_BITS;
  wire        byte_last  = (state_q == sfr_pkg::ST_DATA) && (cnt_q == byte_edges - 6'h01);

  // Opcode-level decisions
  wire        op_wide_cmd = (op_next == sfr_pkg::OP_ENTER_WIDE) ||
                            (op_next == sfr_pkg::OP_EXIT_WIDE);
  wire        op_refused  = busy_s && is_busy_refused(op_next);       // [R13]
  wire        op_dual_in  = (op_next == sfr_pkg::OP_DUAL_ADDR_READ);
  wire        op_dual_out = (op_next == sfr_pkg::OP_DUAL_OUT_READ) || op_dual_in;
  wire        op_takes_addr = (is_read(op_next) || is_short_only(op_next)) && !op_refused;

  // Array fetch: fresh address at the end of the header, else the counter
  wire [MEM_AW-1:0] fetch_addr = (state_q == sfr_pkg::ST_ADDR) ? full_addr[MEM_AW-1:0]
                                                                : addr_q;
  wire [7:0]        fetch_data = mem[fetch_addr];

  // Read pointer step; wraps to zero past the top
  wire [MEM_AW-1:0] next_addr  = fetch_addr + MEM_AW'(1);             // [R9] [R10]

  // Next-state logic
  always_comb begin
    state_d      = state_q;
    cnt_d        = cnt_q + 6'h01;
    op_d         = op_q;
    addr_sr_d    = addr_sr_q;
    addr_d       = addr_q;
    shift_d      = shift_q;
    read_d       = read_q;
    dual_in_d    = dual_in_q;
    dual_out_d   = dual_out_q;
    addr_edges_d = addr_edges_q;
    dummy_d      = dummy_q;
    case (state_q)
      sfr_pkg::ST_OPCODE: begin
        op_d = op_next;                                               // [R19]
        if (op_done) begin
          cnt_d        = 6'h00;
          read_d       = is_read(op_next);
          dual_in_d    = op_dual_in;
          dual_out_d   = op_dual_out;
          dummy_d      = dummy_clocks(op_next, dc_s);
          addr_edges_d = op_dual_in ? (addr_bits(op_next, wide_s) >> 1)    // [R15]
                                    : addr_bits(op_next, wide_s);
          if (op_takes_addr) begin
            state_d = sfr_pkg::ST_ADDR;
          end else begin
            state_d = sfr_pkg::ST_IGNORE;                             // [R7] [R13]
          end
        end
      end
      sfr_pkg::ST_ADDR: begin
        addr_sr_d = sr_next;                                          // [R8] [R19]
        if (addr_last) begin
          cnt_d = 6'h00;
          if (!read_q) begin
            state_d = sfr_pkg::ST_IGNORE;                             // [R6]
          end else if (dummy_q == 4'h0) begin
            state_d = sfr_pkg::ST_DATA;                               // [R11]
            shift_d = fetch_data;
            addr_d  = next_addr;                                      // [R9] [R10]
          end else begin
            state_d = sfr_pkg::ST_DUMMY;
            addr_d  = full_addr[MEM_AW-1:0];                          // [R9]
          end
        end
      end
      sfr_pkg::ST_DUMMY: begin
        if (dummy_last) begin
          cnt_d   = 6'h00;
          state_d = sfr_pkg::ST_DATA;                                 // [R12] [R14] [R15]
          shift_d = fetch_data;
          addr_d  = next_addr;                                        // [R9] [R10]
        end
      end
      sfr_pkg::ST_DATA: begin
        if (byte_last) begin
          cnt_d   = 6'h00;
          shift_d = fetch_data;
          addr_d  = next_addr;                                        // [R9] [R10]
        end else if (dual_out_q) begin
          shift_d = {shift_q[5:0], 2'b00};                            // [R14] [R19]
        end else begin
          shift_d = {shift_q[6:0], 1'b0};                             // [R19]
        end
      end
      sfr_pkg::ST_IGNORE: begin
        cnt_d = cnt_q;
      end
      default: begin
        state_d = sfr_pkg::ST_IGNORE;
        cnt_d   = cnt_q;
      end
    endcase
  end

  // Frame state; chip select high aborts at any point
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      state_q      <= sfr_pkg::ST_OPCODE;                             // [R11]
      cnt_q        <= 6'h00;
      op_q         <= 8'h00;
      addr_sr_q    <= 32'h0000_0000;
      read_q       <= 1'b0;
      dual_in_q    <= 1'b0;
      dual_out_q   <= 1'b0;
      addr_edges_q <= sfr_pkg::SHORT_ADDR_BITS;
      dummy_q      <= 4'h0;
    end else begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      op_q         <= op_d;
      addr_sr_q    <= addr_sr_d;
      read_q       <= read_d;
      dual_in_q    <= dual_in_d;
      dual_out_q   <= dual_out_d;
      addr_edges_q <= addr_edges_d;
      dummy_q      <= dummy_d;
    end
  end

  // Read pointer and output byte
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      addr_q  <= '0;
      shift_q <= 8'h00;
    end else begin
      addr_q  <= addr_d;
      shift_q <= shift_d;
    end
  end

  // Mode commands act on the opcode alone
  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      mode_tog_q <= 2'b00;
    end else if (op_done && op_wide_cmd) begin
      if (op_next == sfr_pkg::OP_ENTER_WIDE) begin
        mode_tog_q[0] <= ~mode_tog_q[0];                              // [R2] [R7]
      end else begin
        mode_tog_q[1] <= ~mode_tog_q[1];                              // [R4] [R7]
      end
    end
  end

  // Output drivers (falling serial clock)

  // Data phase qualifies both enables
  wire data_phase = (state_q == sfr_pkg::ST_DATA);

  // Data leaves on falling edges; line one carries the higher bit
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      o_io_line_one     <= 1'b0;
      o_io_line_one_oe  <= 1'b0;
      o_io_line_zero    <= 1'b0;
      o_io_line_zero_oe <= 1'b0;
    end else begin
      o_io_line_one     <= shift_q[7];                                // [R8] [R19]
      o_io_line_one_oe  <= data_phase;                                // [R8]
      o_io_line_zero    <= dual_out_q & shift_q[6];                   // [R14] [R19]
      o_io_line_zero_oe <= data_phase & dual_out_q;                   // [R14] [R15]
    end
  end

endmodule

`default_nettype wire

// file: testbench/sfr_host.sv
`timescale 1ns/1ns
`default_nettype none
// Host controller model: owns the link clock and chip select
module sfr_host (
  // Link pins
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_io0,
  output logic      o_io1,
  input  wire logic i_io0,
  input  wire logic i_io1
);
  logic [7:0] rx [0:15];
  logic       s0;
  logic       s1;

  // Link idles with clock low and chip select high
  initial begin
    o_sclk = 1'b0;
    o_cs_n <= 1'b1; // Late in the step so the frame reset sees the edge
    // Protect level starts high; frames then toggle it, but no write cycle is started here
    o_io0  = 1'b0;
    o_io1  = 1'b1;
  end

  // One 32 ns link clock; lines change just after the fall
  task automatic tick(input logic b0, input logic b1);
    o_io0 = b0;
    o_io1 = b1;
    #16 o_sclk = 1'b1;
    s0 = i_io0;
    s1 = i_io1;
    #16 o_sclk = 1'b0;
  endtask

  // Whole frame; unused lines carry a changing pattern
  task automatic xfer(input logic [7:0] op, input logic [31:0] a, input int na,
                      input bit da, input int nd, input bit dd, input int nb);
    int i;
    int j;
    o_cs_n = 1'b0;
    #16;
    for (i = 7; i >= 0; i--) tick(op[i], ~o_io1);
    for (i = na - 1; i >= 0; i -= da ? 2 : 1)
      if (da) tick(a[i-1], a[i]);
      else tick(a[i], ~o_io1);
    for (i = 0; i < nd; i++) tick(~o_io0, ~o_io1);
    for (j = 0; j < nb; j++)
      for (i = 7; i >= 0; i -= dd ? 2 : 1) begin
        tick(~o_io0, ~o_io1);
        rx[j][i] = s1;
        if (dd) rx[j][i-1] = s0;
      end
    #16 o_cs_n = 1'b1;
    #64;
  endtask
endmodule
`default_nettype wire

// file: testbench/sfr_props.sv
`timescale 1ns/1ns
`default_nettype none
module sfr_props (
  // Watched ports
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_write_cycle_busy,
  input wire logic i_dummy_count_bit_low,
  input wire logic i_dummy_count_bit_high,
  input wire logic o_wide_address_flag,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_io_line_zero,
  input wire logic o_io_line_zero_oe,
  input wire logic o_io_line_one_oe
);
  logic [7:0] cnt_q;
  logic [7:0] op_q;
  logic [3:0] hi_q;
  logic       quiet;
  logic       oe1;
  logic       oe0;

  // Default setup: idle, default dummies, short addresses
  assign quiet = !i_write_cycle_busy && !i_dummy_count_bit_low
                 && !i_dummy_count_bit_high && !o_wide_address_flag;
  assign oe1   = o_io_line_one_oe;
  assign oe0   = o_io_line_zero_oe;

  // Rises in the frame and the captured opcode
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      cnt_q <= 8'h00;
      op_q  <= 8'h00;
    end else begin
      cnt_q <= cnt_q + {7'h00, cnt_q != 8'hff};
      op_q  <= (cnt_q < 8'h08) ? {op_q[6:0], i_io_line_zero} : op_q;
    end
  end

  // System cycles spent with chip select high
  always_ff @(posedge i_clk) begin
    hi_q <= (i_reset || !i_cs_n) ? 4'h0 : hi_q + {3'h0, hi_q != 4'hf};
  end

  chk_flag_after_reset: assert property (@(posedge i_clk) disable iff (i_reset)
    $fell(i_reset) |-> !o_wide_address_flag) else $error("wide flag set after reset");
  chk_flag_quiet_idle: assert property (@(posedge i_clk) disable iff (i_reset)
    hi_q > 4'h8 |-> $stable(o_wide_address_flag)) else $error("wide flag moved while idle");
  chk_no_early_out: assert property (@(posedge i_sclk) disable iff (i_cs_n)
    (cnt_q < 8'h18 || (cnt_q < 8'h20 && op_q != 8'hbb)) |-> !oe1 && !oe0)
    else $error("output during header");
  chk_read_first_bit: assert property (@(posedge i_sclk) disable iff (i_cs_n)
    quiet && op_q == 8'h03 && cnt_q == 8'h20 |-> oe1 && !oe0) else $error("read data late");
  chk_fast_dummy_len: assert property (@(posedge i_sclk) disable iff (i_cs_n)
    quiet && op_q == 8'h0b && cnt_q == 8'h28 |-> oe1 && !$past(oe1))
    else $error("fast read dummy count");
  chk_dual_out_start: assert property (@(posedge i_sclk) disable iff (i_cs_n)
    quiet && op_q == 8'h3b && cnt_q == 8'h28 |-> oe1 && oe0 && !$past(oe0))
    else $error("dual output start");
  chk_dual_addr_start: assert property (@(posedge i_sclk) disable iff (i_cs_n)
    quiet && op_q == 8'hbb && cnt_q == 8'h18 |-> oe1 && oe0 && !$past(oe1))
    else $error("dual address read start");
  chk_busy_refuse: assert property (@(posedge i_sclk) disable iff (i_cs_n)
    i_write_cycle_busy && op_q inside {8'h0b, 8'h3b, 8'hbb} && cnt_q > 8'h07
    |-> !oe1 && !oe0) else $error("read served while busy");
  chk_zero_line_dual: assert property (@(posedge i_sclk) disable iff (i_cs_n)
    oe0 |-> oe1 && op_q inside {8'h3b, 8'hbb}) else $error("line zero driven off dual");
  chk_short_fmt_quiet: assert property (@(posedge i_sclk) disable iff (i_cs_n)
    op_q inside {8'h5a, 8'hab, 8'h90} && cnt_q > 8'h07 |-> !oe1 && !oe0)
    else $error("short format read drove data");

  cov_read: cover property (@(posedge i_sclk) op_q == 8'h03 && oe1);
  cov_dual: cover property (@(posedge i_sclk) op_q == 8'hbb && oe0);
  cov_busy: cover property (@(posedge i_sclk) i_write_cycle_busy && op_q == 8'h3b);
endmodule

bind sfr_core sfr_props chk_u (
  .i_clk(i_clk), .i_reset(i_reset), .i_write_cycle_busy(i_write_cycle_busy),
  .i_dummy_count_bit_low(i_dummy_count_bit_low), .i_dummy_count_bit_high(i_dummy_count_bit_high),
  .o_wide_address_flag(o_wide_address_flag), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
  .i_io_line_zero(i_io_line_zero), .o_io_line_zero_oe(o_io_line_zero_oe),
  .o_io_line_one_oe(o_io_line_one_oe));
`default_nettype wire

// file: testbench/sfr_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module sfr_tb_top;
  localparam int unsigned AW = 10;
  localparam logic [7:0] OPS [4] = '{8'h03, 8'h0b, 8'h3b, 8'hbb};
  logic          clk, rst, busy, dcl, dch, ld_en, flag, o0, oe0, o1, oe1;
  logic [7:0]    ext, ld_d;
  logic [AW-1:0] ld_a;
  logic [7:0]    mem [0:(1<<AW)-1];
  wire logic     sclk, cs_n, h0, h1, w0, w1;
  int            error_cnt, n_tests, oe_seen, i, k;

  // Wire levels: core output where its enable is set, else the host line
  assign w0 = oe0 ? o0 : h0;
  assign w1 = oe1 ? o1 : h1;

  sfr_core #(.MEM_AW(AW)) dut_u (
    .i_clk(clk), .i_reset(rst), .i_write_cycle_busy(busy),
    .i_dummy_count_bit_low(dcl), .i_dummy_count_bit_high(dch),
    .i_extended_address_bit(ext), .o_wide_address_flag(flag),
    .i_load_en(ld_en), .i_load_addr(ld_a), .i_load_data(ld_d),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_io_line_zero(w0), .i_io_line_one(w1),
    .o_io_line_zero(o0), .o_io_line_zero_oe(oe0), .o_io_line_one(o1), .o_io_line_one_oe(oe1));

  sfr_host host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_io0(h0), .o_io1(h1), .i_io0(w0), .i_io1(w1));

  // System clock and output enable activity
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge oe1 or posedge oe0) oe_seen++;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic int dummies(input bit two_addr, input logic [1:0] dc);
    if (two_addr) return 4 + 2 * int'(dc);
    return (dc == 2'h1) ? 6 : (dc == 2'h3) ? 10 : 8;
  endfunction

  // One read frame: kind 0 normal, 1 fast, 2 dual out, 3 dual addr
  task automatic rd(input int kind, input bit wide, input logic [31:0] a, input int nb);
    int j;
    oe_seen = 0;
    host_u.xfer(OPS[kind], a, wide ? 32 : 24, kind == 3,
                kind == 0 ? 0 : dummies(kind == 3, {dch, dcl}), kind > 1, nb);
    if (busy && kind > 0) check("oe pulses", oe_seen, 0);
    else for (j = 0; j < nb; j++) check("byte", host_u.rx[j], mem[AW'(a + j)]);
  endtask

  // Opcode-only mode frame, then time to settle
  task automatic mode(input logic [7:0] op);
    host_u.xfer(op, 32'h0, 0, 1'b0, 0, 1'b0, 0);
    repeat (10) @(posedge clk);
  endtask

  // Cut a hang short
  initial begin
    #2000000;
    error_cnt++;
    final_report();
  end

  // Main sequence
  initial begin
    void'($urandom(67));
    {busy, dcl, dch, ld_en, ext, ld_a, ld_d} = '0;
    rst <= 1'b1; // Edge lands after every process waits
    error_cnt = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < (1 << AW); i++) begin
      mem[i] = 8'($urandom);
      ld_en <= 1'b1;
      ld_a  <= AW'(i);
      ld_d  <= mem[i];
      @(posedge clk);
    end
    ld_en <= 1'b0;
    @(posedge clk);
    check("wide flag", flag, 1'b0);
    rd(0, 0, 32'h3fd, 5);
    for (k = 0; k < 12; k++) begin
      @(posedge clk);
      {dch, dcl} <= 2'(k / 3);
      ext <= 8'($urandom);
      @(posedge clk);
      rd(k % 3 + 1, 0, 32'($urandom), 1 + $urandom % 4);
    end
    @(posedge clk);
    busy <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 4; k++) rd(k, 0, 32'($urandom), 2);
    @(posedge clk);
    {busy, dch, dcl} <= 3'h0;
    mode(sfr_pkg::OP_ENTER_WIDE);
    check("wide flag", flag, 1'b1);
    for (k = 0; k < 4; k++) rd(k, 1, 32'($urandom), 3);
    for (k = 0; k < 3; k++) begin
      host_u.xfer(k == 0 ? 8'h5a : k == 1 ? 8'hab : 8'h90, 32'h0, 24, 1'b0, 0, 1'b0, 0);
      check("wide flag", flag, 1'b1);
      rd(0, 1, 32'($urandom), 1);
    end
    mode(sfr_pkg::OP_EXIT_WIDE);
    check("wide flag", flag, 1'b0);
    rd(0, 0, 32'h3ff, 2);
    mode(sfr_pkg::OP_ENTER_WIDE);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("wide flag", flag, 1'b0);
    rd(1, 0, 32'($urandom), 2);
    final_report();
  end
endmodule
`default_nettype wire
